/* rtl/pde_override_bank.sv */
// Eight pin override cells that merge port settings with peripheral overrides.
`timescale 1ns/1ps
module pde_override_bank
(
	input wire logic global_pullup_disable,
	input wire logic [7:0] port_dir,
	input wire logic [7:0] port_out,
	input wire logic [7:0] pullup_override_enable,
	input wire logic [7:0] pullup_override_value,
	input wire logic [7:0] direction_override_enable,
	input wire logic [7:0] direction_override_value,
	input wire logic [7:0] value_override_enable,
	input wire logic [7:0] value_override_value,
	input wire logic [7:0] input_enable_override_enable,
	input wire logic [7:0] input_enable_override_value,
	output logic [7:0] pin_out,
	output logic [7:0] pin_oe,
	output logic [7:0] pin_pullup,
	output logic [7:0] pin_in_en
);
	// ----------------------------------------
	// Per-pin merge
	// ----------------------------------------
	// Pure logic, no reset: overrides must hold while the device is in reset.
	genvar i;
	generate
		for (i = 0; i < 8; i++)
		begin : g_pin
			always_comb
			begin
				if (pullup_override_enable[i])
					pin_pullup[i] = pullup_override_value[i];
				else
					pin_pullup[i] = port_out[i] & ~port_dir[i] & ~global_pullup_disable;
				if (direction_override_enable[i])
					pin_oe[i] = direction_override_value[i];
				else
					pin_oe[i] = port_dir[i];
				if (value_override_enable[i])
					pin_out[i] = value_override_value[i];
				else
					pin_out[i] = port_out[i];
				if (input_enable_override_enable[i])
					pin_in_en[i] = input_enable_override_value[i];
				else
					pin_in_en[i] = 1'b1;
			end
		end
	endgenerate
endmodule

/* rtl/pde_pin_override.sv */
// Alternate function override logic for port D and port E pins.
`timescale 1ns/1ps

// What this block does
// - Programmed clock-output fuse drives E7 as output with divided clock.
// - Divided clock on E7 stays active during reset when fuse programmed.
// - Serial port clock on E2 is output when direction bit set.
// - Serial port clock pin function only in synchronous mode.
// - Receiver enabled forces E0 to input and routes it to receiver.
// - Forced-input E0 pull-up follows its output bit, unless pull-ups disabled.
// - Transmitter enabled forces E1 output with transmit data, pull-up off.
// - D1 feeds external interrupt 0; enabled interrupt forces input buffer on.
// - D0 feeds timer capture, with no overrides.
// - Port E pins are pin-change sources; mask and group enable force input.
// - E3 and E2 feed comparator inputs without direction overrides; E2 takes output/pull-up overrides as sync clock.
// - Comparator digital-disable turns input off unless pin-change enabled.
// - Three-wire mode drives E6 with serial data output, direction unchanged.
// - Two-wire mode takes E5 direction, pull-up off, output value zero while its direction bit is set.
// - Two-wire mode takes E4 clock direction, drives zero, toggle strobe.
// - Start-detect interrupt enable forces E5 and E4 input buffers on.
// - Debug port keeps F7, F5, F4 pull-ups on, also in reset.
module pde_pin_override
(
	input wire logic sys_clk,
	input wire logic reset_n,
	// Port D pins and port bits.
	input wire logic [7:0] port_d_pin_in,
	output logic [7:0] port_d_pin_out,
	output logic [7:0] port_d_pin_oe,
	output logic [7:0] port_d_pullup,
	output logic [7:0] port_d_in_en,
	input wire logic [7:0] port_d_dir,
	input wire logic [7:0] port_d_out,
	// Port E pins and port bits.
	input wire logic [7:0] port_e_pin_in,
	output logic [7:0] port_e_pin_out,
	output logic [7:0] port_e_pin_oe,
	output logic [7:0] port_e_pullup,
	output logic [7:0] port_e_in_en,
	output logic [7:0] port_e_toggle,
	input wire logic [7:0] port_e_dir,
	input wire logic [7:0] port_e_out,
	input wire logic global_pullup_disable,
	// Clock output.
	input wire logic clock_out_fuse,
	input wire logic io_clock,
	// Serial port.
	input wire logic receiver_on,
	input wire logic transmitter_on,
	input wire logic transmit_data,
	input wire logic serial_sync_mode,
	input wire logic sync_serial_clock_out,
	output logic receive_data_in,
	output logic sync_serial_clock_in,
	// Serial interface.
	input wire logic three_wire_mode_active,
	input wire logic two_wire_mode_active,
	input wire logic serial_data_out,
	input wire logic clock_hold_low,
	input wire logic clock_toggle_strobe,
	input wire logic start_detect_irq_enable,
	output logic serial_in_pin,
	output logic serial_if_clock_pin,
	// Interrupts, timer and comparator.
	input wire logic ext_irq0_enable,
	output logic ext_irq0_input,
	output logic timer_capture_input,
	input wire logic [7:0] pin_change_mask_bit,
	input wire logic pin_change_group_enable,
	output logic [7:0] pin_change_input,
	output logic [7:0] pin_change_event,
	input wire logic comp_pos_input_disable,
	input wire logic comp_neg_input_disable,
	// Digital readback of both ports.
	output logic [7:0] port_d_read,
	output logic [7:0] port_e_read,
	// Debug port pull-ups on port F.
	input wire logic debug_port_enable,
	output logic [7:0] port_f_pullup_force
);
	logic [7:0] e_pullup_override_enable;
	logic [7:0] e_pullup_override_value;
	logic [7:0] e_direction_override_enable;
	logic [7:0] e_direction_override_value;
	logic [7:0] e_value_override_enable;
	logic [7:0] e_value_override_value;
	logic [7:0] e_input_enable_override_enable;
	logic [7:0] e_input_enable_override_value;
	logic [7:0] d_input_enable_override_enable;
	logic [7:0] d_input_enable_override_value;
	logic [7:0] pc_enabled;
	logic xck_out_en;
	logic [15:0] pin_sync;
	logic [7:0] d_digital;
	logic [7:0] e_digital;
	logic [7:0] next_pin_change_event;

	// ----------------------------------------
	// Pin-change enables
	// ----------------------------------------
	assign pc_enabled = pin_change_mask_bit & {8{pin_change_group_enable}};

	// The clock pin drives the serial clock only in synchronous mode and with its direction bit set.
	assign xck_out_en = serial_sync_mode & port_e_dir[pde_pkg::E_XCK];

	// ----------------------------------------
	// Port E pull-up overrides
	// ----------------------------------------
	always_comb
	begin
		e_pullup_override_enable = '0;
		e_pullup_override_value = '0;
		e_pullup_override_enable[pde_pkg::E_SDA] = two_wire_mode_active;
		e_pullup_override_value[pde_pkg::E_SDA] = 1'b0;
		e_pullup_override_enable[pde_pkg::E_XCK] = xck_out_en;
		e_pullup_override_value[pde_pkg::E_XCK] = 1'b0;
		e_pullup_override_enable[pde_pkg::E_TXD] = transmitter_on;
		e_pullup_override_value[pde_pkg::E_TXD] = 1'b0;
		e_pullup_override_enable[pde_pkg::E_RXD] = receiver_on;
		e_pullup_override_value[pde_pkg::E_RXD] = port_e_out[pde_pkg::E_RXD] & ~global_pullup_disable;
	end

	// ----------------------------------------
	// Port E direction overrides
	// ----------------------------------------
	// Comparator pins carry no direction override at all.
	always_comb
	begin
		e_direction_override_enable = '0;
		e_direction_override_value = '0;
		e_direction_override_enable[pde_pkg::E_DIVIDED_CLOCK_PIN] = clock_out_fuse;
		e_direction_override_value[pde_pkg::E_DIVIDED_CLOCK_PIN] = 1'b1;
		e_direction_override_enable[pde_pkg::E_SDA] = two_wire_mode_active;
		e_direction_override_value[pde_pkg::E_SDA] = (~serial_data_out | port_e_out[pde_pkg::E_SDA])
			& port_e_dir[pde_pkg::E_SDA];
		e_direction_override_enable[pde_pkg::E_SCL] = two_wire_mode_active;
		e_direction_override_value[pde_pkg::E_SCL] = (clock_hold_low | port_e_out[pde_pkg::E_SCL])
			& port_e_dir[pde_pkg::E_SCL];
		e_direction_override_enable[pde_pkg::E_TXD] = transmitter_on;
		e_direction_override_value[pde_pkg::E_TXD] = 1'b1;
		e_direction_override_enable[pde_pkg::E_RXD] = receiver_on;
		e_direction_override_value[pde_pkg::E_RXD] = 1'b0;
	end

	// ----------------------------------------
	// Port E value overrides
	// ----------------------------------------
	// The clock output is a straight gate path so it keeps running through reset.
	always_comb
	begin
		e_value_override_enable = '0;
		e_value_override_value = '0;
		e_value_override_enable[pde_pkg::E_DIVIDED_CLOCK_PIN] = clock_out_fuse;
		e_value_override_value[pde_pkg::E_DIVIDED_CLOCK_PIN] = io_clock;
		e_value_override_enable[pde_pkg::E_SDO] = three_wire_mode_active;
		e_value_override_value[pde_pkg::E_SDO] = serial_data_out;
		e_value_override_enable[pde_pkg::E_SDA] = two_wire_mode_active & port_e_dir[pde_pkg::E_SDA];
		e_value_override_value[pde_pkg::E_SDA] = 1'b0;
		e_value_override_enable[pde_pkg::E_SCL] = two_wire_mode_active & port_e_dir[pde_pkg::E_SCL];
		e_value_override_value[pde_pkg::E_SCL] = 1'b0;
		e_value_override_enable[pde_pkg::E_XCK] = xck_out_en;
		e_value_override_value[pde_pkg::E_XCK] = sync_serial_clock_out;
		e_value_override_enable[pde_pkg::E_TXD] = transmitter_on;
		e_value_override_value[pde_pkg::E_TXD] = transmit_data;
	end

	// ----------------------------------------
	// Port E input buffer overrides
	// ----------------------------------------
	always_comb
	begin
		e_input_enable_override_enable = pc_enabled;
		e_input_enable_override_value = 8'hFF;
		e_input_enable_override_enable[pde_pkg::E_SDA] = pc_enabled[pde_pkg::E_SDA] | start_detect_irq_enable;
		e_input_enable_override_enable[pde_pkg::E_SCL] = pc_enabled[pde_pkg::E_SCL] | start_detect_irq_enable;
		// A pin-change source keeps the buffer alive despite the disable bit.
		e_input_enable_override_enable[pde_pkg::E_CMP_NEG] = pc_enabled[pde_pkg::E_CMP_NEG] | comp_neg_input_disable;
		e_input_enable_override_value[pde_pkg::E_CMP_NEG] = pc_enabled[pde_pkg::E_CMP_NEG];
		e_input_enable_override_enable[pde_pkg::E_XCK] = pc_enabled[pde_pkg::E_XCK] | comp_pos_input_disable;
		e_input_enable_override_value[pde_pkg::E_XCK] = pc_enabled[pde_pkg::E_XCK];
	end

	// ----------------------------------------
	// Port D input buffer overrides
	// ----------------------------------------
	// Only the interrupt pin has an override; capture and D3..D2 stay plain.
	always_comb
	begin
		d_input_enable_override_enable = '0;
		d_input_enable_override_value = '0;
		d_input_enable_override_enable[pde_pkg::D_IRQ0] = ext_irq0_enable;
		d_input_enable_override_value[pde_pkg::D_IRQ0] = ext_irq0_enable;
	end

	// ----------------------------------------
	// Pin cells
	// ----------------------------------------
	pde_override_bank u_bank_e
	(
		.global_pullup_disable(global_pullup_disable),
		.port_dir(port_e_dir),
		.port_out(port_e_out),
		.pullup_override_enable(e_pullup_override_enable),
		.pullup_override_value(e_pullup_override_value),
		.direction_override_enable(e_direction_override_enable),
		.direction_override_value(e_direction_override_value),
		.value_override_enable(e_value_override_enable),
		.value_override_value(e_value_override_value),
		.input_enable_override_enable(e_input_enable_override_enable),
		.input_enable_override_value(e_input_enable_override_value),
		.pin_out(port_e_pin_out),
		.pin_oe(port_e_pin_oe),
		.pin_pullup(port_e_pullup),
		.pin_in_en(port_e_in_en)
	);

	// Port D has no pull-up, direction or value override on any pin.
	pde_override_bank u_bank_d
	(
		.global_pullup_disable(global_pullup_disable),
		.port_dir(port_d_dir),
		.port_out(port_d_out),
		.pullup_override_enable(8'h00),
		.pullup_override_value(8'h00),
		.direction_override_enable(8'h00),
		.direction_override_value(8'h00),
		.value_override_enable(8'h00),
		.value_override_value(8'h00),
		.input_enable_override_enable(d_input_enable_override_enable),
		.input_enable_override_value(d_input_enable_override_value),
		.pin_out(port_d_pin_out),
		.pin_oe(port_d_pin_oe),
		.pin_pullup(port_d_pullup),
		.pin_in_en(port_d_in_en)
	);

	// The clock pin toggle request goes to the port register; only in two-wire use.
	always_comb
	begin
		port_e_toggle = '0;
		port_e_toggle[pde_pkg::E_SCL] = two_wire_mode_active & clock_toggle_strobe;
	end

	// Not held by reset, so the debug pull-ups survive a reset.
	assign port_f_pullup_force = pde_pkg::F_DEBUG_PULLUP_MASK & {8{debug_port_enable}};

	// ----------------------------------------
	// Input path
	// ----------------------------------------
	pde_sync u_sync
	(
		.sys_clk(sys_clk),
		.reset_n(reset_n),
		.async_in({port_e_pin_in, port_d_pin_in}),
		.sync_out(pin_sync)
	);

	// A disabled input buffer reads as zero, which also keeps analog pins quiet.
	assign d_digital = pin_sync[7:0] & port_d_in_en;
	assign e_digital = pin_sync[15:8] & port_e_in_en;

	always_ff @(posedge sys_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			port_d_read <= pde_pkg::RESET_BYTE;
			port_e_read <= pde_pkg::RESET_BYTE;
		end
		else
		begin
			port_d_read <= d_digital;
			port_e_read <= e_digital;
		end
	end

	// ----------------------------------------
	// Peripheral inputs
	// ----------------------------------------
	always_ff @(posedge sys_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			ext_irq0_input <= pde_pkg::RESET_BIT;
			timer_capture_input <= pde_pkg::RESET_BIT;
		end
		else
		begin
			ext_irq0_input <= d_digital[pde_pkg::D_IRQ0];
			timer_capture_input <= d_digital[pde_pkg::D_CAPT];
		end
	end

	always_ff @(posedge sys_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			receive_data_in <= pde_pkg::RESET_BIT;
			sync_serial_clock_in <= pde_pkg::RESET_BIT;
		end
		else
		begin
			receive_data_in <= e_digital[pde_pkg::E_RXD];
			// Outside synchronous mode the clock pin feeds nothing.
			sync_serial_clock_in <= serial_sync_mode & e_digital[pde_pkg::E_XCK];
		end
	end

	always_ff @(posedge sys_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			serial_in_pin <= pde_pkg::RESET_BIT;
			serial_if_clock_pin <= pde_pkg::RESET_BIT;
		end
		else
		begin
			serial_in_pin <= e_digital[pde_pkg::E_SDA];
			serial_if_clock_pin <= e_digital[pde_pkg::E_SCL];
		end
	end

	// ----------------------------------------
	// Pin-change detection
	// ----------------------------------------
	// One cycle per level change of an enabled source; a source enabled while its
	// buffer was off may report one change as the buffer comes up.
	assign next_pin_change_event = (e_digital ^ pin_change_input) & pc_enabled;

	always_ff @(posedge sys_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			pin_change_input <= pde_pkg::RESET_BYTE;
			pin_change_event <= pde_pkg::RESET_BYTE;
		end
		else
		begin
			pin_change_input <= e_digital;
			pin_change_event <= next_pin_change_event;
		end
	end
endmodule

/* rtl/pde_pkg.sv */
// Constants shared by the port D and port E pin override logic.
package pde_pkg;
	localparam int unsigned PORT_W = 8;
	// Port E pin positions.
	localparam int unsigned E_DIVIDED_CLOCK_PIN = 7;
	localparam int unsigned E_SDO = 6;
	localparam int unsigned E_SDA = 5;
	localparam int unsigned E_SCL = 4;
	localparam int unsigned E_CMP_NEG = 3;
	localparam int unsigned E_XCK = 2;
	localparam int unsigned E_TXD = 1;
	localparam int unsigned E_RXD = 0;
	// Port D pin positions.
	localparam int unsigned D_IRQ0 = 1;
	localparam int unsigned D_CAPT = 0;
	// Port F pins whose pull-ups the debug port keeps on.
	localparam logic [7:0] F_DEBUG_PULLUP_MASK = 8'hB0;
	// Reset values of the registered outputs.
	localparam logic [7:0] RESET_BYTE = 8'h00;
	localparam logic RESET_BIT = 1'b0;
endpackage

/* rtl/pde_sync.sv */
// Two-flop synchroniser for the pin inputs.
`timescale 1ns/1ps
module pde_sync
(
	input wire logic sys_clk,
	input wire logic reset_n,
	input wire logic [15:0] async_in,
	output logic [15:0] sync_out
);
	logic [15:0] stage1;

	// ----------------------------------------
	// Per-bit synchroniser
	// ----------------------------------------
	// The first stage feeds only the second one, to keep metastability contained.
	genvar i;
	generate
		for (i = 0; i < 16; i++)
		begin : g_bit
			always_ff @(posedge sys_clk or negedge reset_n)
			begin
				if (!reset_n)
				begin
					stage1[i] <= pde_pkg::RESET_BIT;
					sync_out[i] <= pde_pkg::RESET_BIT;
				end
				else
				begin
					stage1[i] <= async_in[i];
					sync_out[i] <= stage1[i];
				end
			end
		end
	endgenerate
endmodule

/* test/pde_pad_model.sv */
// Pads of one port with the external circuitry attached.
`timescale 1ns/1ps
module pde_pad_model
(
	input wire logic sys_clk,
	input wire logic [7:0] pin_out,
	input wire logic [7:0] pin_oe,
	input wire logic [7:0] pull_on,
	input wire logic [7:0] ext_drive,
	input wire logic [7:0] ext_val,
	output logic [7:0] pad
);
	logic [7:0] drift;
	// A floating pad without pull-up wanders, so a stale level is never trusted.
	always_ff @(posedge sys_clk)
		drift <= ~pad;
	assign pad = (pin_oe & pin_out) | (~pin_oe & ext_drive & ext_val) | (~pin_oe & ~ext_drive & (pull_on | drift));
endmodule

/* test/pde_pin_override_asserts.sv */
// Port-level assertions for the pin override block.
`timescale 1ns/1ps
module pde_pin_override_asserts
(
	input wire logic sys_clk,
	input wire logic reset_n,
	input wire logic [7:0] port_e_pin_out,
	input wire logic [7:0] port_e_pin_oe,
	input wire logic [7:0] port_e_pullup,
	input wire logic [7:0] port_e_in_en,
	input wire logic [7:0] port_e_toggle,
	input wire logic [7:0] port_e_dir,
	input wire logic [7:0] port_e_out,
	input wire logic global_pullup_disable,
	input wire logic clock_out_fuse,
	input wire logic io_clock,
	input wire logic receiver_on,
	input wire logic transmitter_on,
	input wire logic transmit_data,
	input wire logic serial_sync_mode,
	input wire logic sync_serial_clock_out,
	input wire logic three_wire_mode_active,
	input wire logic two_wire_mode_active,
	input wire logic serial_data_out,
	input wire logic clock_hold_low,
	input wire logic clock_toggle_strobe,
	input wire logic [7:0] pin_change_mask_bit,
	input wire logic pin_change_group_enable,
	input wire logic comp_pos_input_disable,
	input wire logic comp_neg_input_disable,
	input wire logic debug_port_enable,
	input wire logic [7:0] port_f_pullup_force
);
	default clocking @(posedge sys_clk);
	endclocking
	default disable iff (!reset_n);
	// ----------------------------------------
	// Override relations
	// ----------------------------------------
	a_clk_out_drive: assert property (clock_out_fuse |-> port_e_pin_oe[7] && port_e_pin_out[7] == io_clock)
		else $error("clock pin not driven");
	a_rx_forces_in: assert property (receiver_on |-> !port_e_pin_oe[0]
		&& port_e_pullup[0] == (port_e_out[0] && !global_pullup_disable)) else $error("receive pin wrong");
	a_tx_forces_out: assert property (transmitter_on |-> port_e_pin_oe[1] && !port_e_pullup[1]
		&& port_e_pin_out[1] == transmit_data) else $error("transmit pin wrong");
	a_sync_clk_pin: assert property (port_e_pin_oe[3:2] == port_e_dir[3:2]
		&& port_e_pin_out[2] == ((serial_sync_mode && port_e_dir[2]) ? sync_serial_clock_out : port_e_out[2]))
		else $error("serial clock pin wrong");
	a_comp_in_gate: assert property (port_e_in_en[3:2] == ~({comp_neg_input_disable, comp_pos_input_disable}
		& ~({2{pin_change_group_enable}} & pin_change_mask_bit[3:2]))) else $error("comparator input gate wrong");
	a_three_wire: assert property (three_wire_mode_active |-> port_e_pin_out[6] == serial_data_out)
		else $error("data out pin wrong");
	a_two_wire_data: assert property (two_wire_mode_active |-> !port_e_pullup[5]
		&& port_e_pin_oe[5] == ((!serial_data_out || port_e_out[5]) && port_e_dir[5])
		&& port_e_pin_out[5] == (port_e_out[5] && !port_e_dir[5])) else $error("data pin wrong");
	a_two_wire_clk: assert property (port_e_toggle == {3'h0, two_wire_mode_active && clock_toggle_strobe, 4'h0}
		&& (!two_wire_mode_active || port_e_pin_oe[4] == ((clock_hold_low || port_e_out[4]) && port_e_dir[4])))
		else $error("clock pin wrong");
	a_debug_pullup: assert property (port_f_pullup_force == (debug_port_enable ? 8'hB0 : 8'h00))
		else $error("debug pull-ups wrong");
endmodule
bind pde_pin_override pde_pin_override_asserts u_pde_pin_override_asserts (.*);

/* test/port_d_e_alternate_override_test.sv */
// Self-checking bench for the pin override block.
`timescale 1ns/1ps
module port_d_e_alternate_override_test;
	logic sys_clk, reset_n, global_pullup_disable, clock_out_fuse, io_clock, receiver_on, transmitter_on;
	logic transmit_data, serial_sync_mode, sync_serial_clock_out, three_wire_mode_active, two_wire_mode_active;
	logic serial_data_out, clock_hold_low, clock_toggle_strobe, start_detect_irq_enable, ext_irq0_enable;
	logic pin_change_group_enable, comp_pos_input_disable, comp_neg_input_disable, debug_port_enable;
	logic receive_data_in, sync_serial_clock_in, serial_in_pin, serial_if_clock_pin, ext_irq0_input;
	logic timer_capture_input;
	logic [7:0] port_d_pin_in, port_d_pin_out, port_d_pin_oe, port_d_pullup, port_d_in_en, port_d_dir, port_d_out;
	logic [7:0] port_e_pin_in, port_e_pin_out, port_e_pin_oe, port_e_pullup, port_e_in_en, port_e_dir, port_e_out;
	logic [7:0] port_e_toggle, pin_change_mask_bit, pin_change_input, pin_change_event, port_d_read, port_e_read;
	logic [7:0] port_f_pullup_force, d_ext_val, e_ext_val;
	int err_count = 0;
	int total_checks = 0;
	int cycles = 0;
	pde_pin_override u_pde_pin_override (.*);
	pde_pad_model u_pde_pad_model_d (.sys_clk(sys_clk), .pin_out(port_d_pin_out), .pin_oe(port_d_pin_oe),
		.pull_on(port_d_pullup), .ext_drive(8'hFF), .ext_val(d_ext_val), .pad(port_d_pin_in));
	pde_pad_model u_pde_pad_model_e (.sys_clk(sys_clk), .pin_out(port_e_pin_out), .pin_oe(port_e_pin_oe),
		.pull_on(port_e_pullup), .ext_drive(8'hFF), .ext_val(e_ext_val), .pad(port_e_pin_in));
	initial
	begin
		sys_clk = 1'b0;
		forever #12.5 sys_clk = ~sys_clk;
	end
	// ----------------------------------------
	// Shared tasks
	// ----------------------------------------
	task automatic step(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask
	task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
		total_checks++;
		if (seen !== exp)
		begin
			err_count++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic idle;
		{global_pullup_disable, clock_out_fuse, io_clock, receiver_on, transmitter_on, transmit_data} = '0;
		{serial_sync_mode, sync_serial_clock_out, three_wire_mode_active, two_wire_mode_active} = '0;
		{serial_data_out, clock_hold_low, clock_toggle_strobe, start_detect_irq_enable, ext_irq0_enable} = '0;
		{pin_change_group_enable, comp_pos_input_disable, comp_neg_input_disable, debug_port_enable} = '0;
		{port_d_dir, port_d_out, port_e_dir, port_e_out, pin_change_mask_bit, d_ext_val, e_ext_val} = '0;
	endtask
	task automatic give_verdict;
		$display("checks %0d mismatches %0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_in_reset;
		clock_out_fuse = 1'b1;
		debug_port_enable = 1'b1;
		for (int v = 0; v < 2; v++)
		begin
			io_clock = v[0];
			step(1);
			check("e7 oe", port_e_pin_oe[7], 1'b1);
			check("e7 out", port_e_pin_out[7], v[0]);
		end
		check("f pull-ups", port_f_pullup_force, 8'hB0);
		// Port F outputs are never switched here, so no conversion can be upset.
		idle();
		step(1);
		check("e7 oe off", port_e_pin_oe[7], 1'b0);
		$display("test in_reset done");
	endtask
	task automatic t_usart;
		idle();
		clock_out_fuse = 1'b1;
		io_clock = 1'b1;
		port_e_dir = 8'h01;
		port_e_out = 8'h01;
		receiver_on = 1'b1;
		e_ext_val = 8'h01;
		step(1);
		check("e7 after reset", {port_e_pin_oe[7], port_e_pin_out[7]}, 2'h3);
		check("e0 oe", port_e_pin_oe[0], 1'b0);
		check("e0 pull-up", port_e_pullup[0], 1'b1);
		global_pullup_disable = 1'b1;
		step(3);
		check("e0 pull-up off", port_e_pullup[0], 1'b0);
		check("rx data", receive_data_in, 1'b1);
		idle();
		transmitter_on = 1'b1;
		port_e_out = 8'h02;
		for (int v = 0; v < 2; v++)
		begin
			transmit_data = v[0];
			step(1);
			check("e1", {port_e_pullup[1], port_e_pin_oe[1], port_e_pin_out[1]}, {2'h1, v[0]});
		end
		$display("test usart done");
	endtask
	task automatic t_sync_clock;
		idle();
		serial_sync_mode = 1'b1;
		sync_serial_clock_out = 1'b1;
		port_e_dir = 8'h04;
		step(1);
		check("e2 out", {port_e_pin_oe[2], port_e_pin_out[2]}, 2'h3);
		port_e_dir = 8'h00;
		e_ext_val = 8'h04;
		step(3);
		check("e2 in", port_e_pin_oe[2], 1'b0);
		check("e2 clock in", sync_serial_clock_in, 1'b1);
		serial_sync_mode = 1'b0;
		port_e_dir = 8'h0C;
		port_e_out = 8'h08;
		step(1);
		check("e3 e2 plain", {port_e_pin_oe[3:2], port_e_pin_out[3:2]}, 4'hE);
		check("e2 clock gated", sync_serial_clock_in, 1'b0);
		$display("test sync_clock done");
	endtask
	task automatic t_usi;
		idle();
		three_wire_mode_active = 1'b1;
		for (int v = 0; v < 2; v++)
		begin
			serial_data_out = v[0];
			step(1);
			check("e6", {port_e_pin_oe[6], port_e_pin_out[6]}, v[0]);
		end
		idle();
		two_wire_mode_active = 1'b1;
		start_detect_irq_enable = 1'b1;
		for (int k = 0; k < 16; k++)
		begin
			port_e_dir = {2'h0, k[1], k[1], 4'h0};
			port_e_out = {2'h0, k[0], k[0], 4'h0};
			serial_data_out = k[2];
			clock_hold_low = k[2];
			clock_toggle_strobe = k[3];
			step(1);
			check("e5", {port_e_pullup[5], port_e_pin_oe[5], port_e_pin_out[5]}, {(~k[2] | k[0]) & k[1], k[0] & ~k[1]});
			check("e4", {port_e_pin_oe[4], port_e_pin_out[4]}, {(k[2] | k[0]) & k[1], k[0] & ~k[1]});
			check("toggle", port_e_toggle, {3'h0, k[3], 4'h0});
		end
		check("e5 e4 inputs", port_e_in_en[5:4], 2'h3);
		port_e_dir = 8'h00;
		e_ext_val = 8'h20;
		step(3);
		check("usi pins in", {serial_in_pin, serial_if_clock_pin}, 2'h2);
		$display("test usi done");
	endtask
	task automatic t_inputs;
		idle();
		ext_irq0_enable = 1'b1;
		d_ext_val = 8'h03;
		port_d_dir = 8'h08;
		port_d_out = 8'h0C;
		e_ext_val = 8'h0C;
		comp_neg_input_disable = 1'b1;
		comp_pos_input_disable = 1'b1;
		pin_change_group_enable = 1'b1;
		pin_change_mask_bit = 8'h84;
		step(4);
		check("d capture irq", {timer_capture_input, ext_irq0_input, port_d_in_en[1]}, 3'h7);
		check("d plain", {port_d_pin_oe[3:0], port_d_pin_out[3:0]}, 8'h8C);
		check("d pull-up", port_d_pullup[3:0], 4'h4);
		check("comp read", port_e_read[3:2], 2'h1);
		d_ext_val = 8'h00;
		e_ext_val = 8'h8C;
		step(2);
		check("irq hold", ext_irq0_input, 1'b1);
		step(1);
		check("irq new", ext_irq0_input, 1'b0);
		check("e change", pin_change_event, 8'h80);
		check("e change in", pin_change_input, 8'h84);
		check("e read", port_e_read, 8'h84);
		check("d read", port_d_read, 8'h08);
		step(1);
		check("e7 pulse", pin_change_event[7], 1'b0);
		pin_change_group_enable = 1'b0;
		e_ext_val = 8'h0C;
		step(3);
		check("e7 masked", pin_change_event[7], 1'b0);
		$display("test inputs done");
	endtask
	always @(posedge sys_clk)
	begin
		cycles++;
		if (cycles == 2000)
		begin
			err_count++;
			give_verdict();
		end
	end
	initial
	begin
		reset_n = 1'b0;
		idle();
		t_in_reset();
		step(5);
		reset_n = 1'b1;
		t_usart();
		t_sync_clock();
		t_usi();
		t_inputs();
		give_verdict();
	end
endmodule
